// file: hdl/eled_pkg.sv
// package for the external line event detector: offsets, reset values, carriers
package eled_pkg;
   localparam int         ELED_LINES    = 16;
   localparam int         ELED_PINS     = 32;
   localparam int         ELED_SELW     = 5;
   localparam int         ELED_SEL_PER  = 4;
   localparam int         ELED_SEL_STEP = 8;
   localparam logic [7:0] ELED_OFS_IRQ_EN  = 8'h00;
   localparam logic [7:0] ELED_OFS_EVT_EN  = 8'h04;
   localparam logic [7:0] ELED_OFS_RISE_EN = 8'h08;
   localparam logic [7:0] ELED_OFS_FALL_EN = 8'h0C;
   localparam logic [7:0] ELED_OFS_PENDING = 8'h10;
   localparam logic [7:0] ELED_OFS_SEL0    = 8'h18;
   localparam logic [7:0] ELED_OFS_SEL1    = 8'h1C;
   localparam logic [7:0] ELED_OFS_SEL2    = 8'h20;
   localparam logic [7:0] ELED_OFS_SEL3    = 8'h24;
   localparam logic [15:0] ELED_RST_LINES  = 16'h0000;
   localparam logic [4:0]  ELED_RST_SEL    = 5'h00;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } eled_bus_req_t;

   typedef struct packed {
      logic [15:0]      irq_en;
      logic [15:0]      evt_en;
      logic [15:0]      rise_en;
      logic [15:0]      fall_en;
      logic [15:0]      pending;
      logic [15:0][4:0] src_sel;
      logic [15:0]      rise_s1;
      logic [15:0]      rise_s2;
      logic [15:0]      rise_s3;
      logic [15:0]      fall_s1;
      logic [15:0]      fall_s2;
      logic [15:0]      fall_s3;
      logic [31:0]      rd_data;
      logic [15:0]      evt_out;
      logic             irq;
      logic             wake;
   } eled_state_t;
endpackage

// file: hdl/eled_top.sv
// external line event detector: edge catchers, register file and request outputs
`timescale 1ns/100ps
`default_nettype none

// catches edges of one routed line on the line itself, so pulses shorter than clk are kept
module eled_edge_catch (
   // line and reset
   input  wire logic pin,
   input  wire logic rst_n,
   // toggles, one flip per edge
   output var  logic rise_tog,
   output var  logic fall_tog
);
   always_ff @(posedge pin or negedge rst_n) begin
      if (!rst_n) begin
         rise_tog <= 1'b0;
      end else begin
         rise_tog <= ~rise_tog;
      end
   end

   always_ff @(negedge pin or negedge rst_n) begin
      if (!rst_n) begin
         fall_tog <= 1'b0;
      end else begin
         fall_tog <= ~fall_tog;
      end
   end
endmodule // eled_edge_catch

// Summary of operation
// - each line triggers on rising, falling or both
// - per-line mask blocks its interrupt and event
// - detected triggers latch in a pending register
// - pulses narrower than clk are still caught
// - sixteen lines, each routed from any pin
// - unmasked edges raise interrupt, event and wakeup
module eled_top import eled_pkg::*; (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   // register port
   input  wire eled_bus_req_t bus,
   output var  logic [31:0]   rd_data,
   // pins
   input  wire logic [31:0]   gpio_pins,
   // requests
   output var  logic          irq,
   output var  logic [15:0]   evt_out,
   output var  logic          wake
);
   logic        rst_meta;
   logic        rst_n;
   eled_state_t st;
   eled_state_t next_st;
   logic [15:0] line_src;
   logic [15:0] rise_tog;
   logic [15:0] fall_tog;
   logic [15:0] rise_hit;
   logic [15:0] fall_hit;
   logic [15:0] hit;
   logic [15:0] w1c;
   logic [31:0] rd_mux;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // a change of routing can itself look like an edge; software should mask first
   genvar gi;
   generate
      for (gi = 0; gi < ELED_LINES; gi++) begin : g_line
         assign line_src[gi] = gpio_pins[st.src_sel[gi]];
         eled_edge_catch u_catch (
            .pin      (line_src[gi]),
            .rst_n    (rst_n),
            .rise_tog (rise_tog[gi]),
            .fall_tog (fall_tog[gi])
         );
      end
   endgenerate

   always_comb begin
      next_st = st;
      // toggles cross by two flops, third flop only for change detection
      next_st.rise_s1 = rise_tog;
      next_st.rise_s2 = st.rise_s1;
      next_st.rise_s3 = st.rise_s2;
      next_st.fall_s1 = fall_tog;
      next_st.fall_s2 = st.fall_s1;
      next_st.fall_s3 = st.fall_s2;
      rise_hit = (st.rise_s2 ^ st.rise_s3) & st.rise_en;
      fall_hit = (st.fall_s2 ^ st.fall_s3) & st.fall_en;
      hit      = rise_hit | fall_hit;
      w1c      = 16'h0000;
      if (bus.wr) begin
         if (bus.addr == ELED_OFS_IRQ_EN) begin
            next_st.irq_en = bus.wdata[15:0];
         end else if (bus.addr == ELED_OFS_EVT_EN) begin
            next_st.evt_en = bus.wdata[15:0];
         end else if (bus.addr == ELED_OFS_RISE_EN) begin
            next_st.rise_en = bus.wdata[15:0];
         end else if (bus.addr == ELED_OFS_FALL_EN) begin
            next_st.fall_en = bus.wdata[15:0];
         end else if (bus.addr == ELED_OFS_PENDING) begin
            w1c = bus.wdata[15:0];
         end else if (bus.addr == ELED_OFS_SEL0 || bus.addr == ELED_OFS_SEL1 ||
                      bus.addr == ELED_OFS_SEL2 || bus.addr == ELED_OFS_SEL3) begin
            for (int k = 0; k < ELED_SEL_PER; k++) begin
               next_st.src_sel[(int'(bus.addr - ELED_OFS_SEL0) >> 2) * ELED_SEL_PER + k] =
                  bus.wdata[k*ELED_SEL_STEP +: ELED_SELW];
            end
         end
      end
      // a new edge wins over a clear in the same cycle
      next_st.pending = (st.pending & ~w1c) | hit;
      rd_mux = 32'h0000_0000;
      if (bus.addr == ELED_OFS_IRQ_EN) begin
         rd_mux[15:0] = st.irq_en;
      end else if (bus.addr == ELED_OFS_EVT_EN) begin
         rd_mux[15:0] = st.evt_en;
      end else if (bus.addr == ELED_OFS_RISE_EN) begin
         rd_mux[15:0] = st.rise_en;
      end else if (bus.addr == ELED_OFS_FALL_EN) begin
         rd_mux[15:0] = st.fall_en;
      end else if (bus.addr == ELED_OFS_PENDING) begin
         rd_mux[15:0] = st.pending;
      end else if (bus.addr == ELED_OFS_SEL0 || bus.addr == ELED_OFS_SEL1 ||
                   bus.addr == ELED_OFS_SEL2 || bus.addr == ELED_OFS_SEL3) begin
         for (int k = 0; k < ELED_SEL_PER; k++) begin
            rd_mux[k*ELED_SEL_STEP +: ELED_SELW] =
               st.src_sel[(int'(bus.addr - ELED_OFS_SEL0) >> 2) * ELED_SEL_PER + k];
         end
      end
      next_st.rd_data = bus.rd ? rd_mux : 32'h0000_0000;
      next_st.irq     = |(next_st.pending & next_st.irq_en);
      next_st.evt_out = hit & st.evt_en;
      // wake is raised by any request so a stopped core sees it without polling
      next_st.wake    = next_st.irq | (|next_st.evt_out);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st.irq_en  <= ELED_RST_LINES;
         st.evt_en  <= ELED_RST_LINES;
         st.rise_en <= ELED_RST_LINES;
         st.fall_en <= ELED_RST_LINES;
         st.pending <= ELED_RST_LINES;
         st.src_sel <= {ELED_LINES{ELED_RST_SEL}};
         st.rise_s1 <= ELED_RST_LINES;
         st.rise_s2 <= ELED_RST_LINES;
         st.rise_s3 <= ELED_RST_LINES;
         st.fall_s1 <= ELED_RST_LINES;
         st.fall_s2 <= ELED_RST_LINES;
         st.fall_s3 <= ELED_RST_LINES;
         st.rd_data <= 32'h0000_0000;
         st.evt_out <= ELED_RST_LINES;
         st.irq     <= 1'b0;
         st.wake    <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = st.rd_data;
   assign irq     = st.irq;
   assign evt_out = st.evt_out;
   assign wake    = st.wake;

   sequence s_rise_seen;
      (rise_hit != 16'h0000);
   endsequence

   sequence s_rise_logged;
      ((st.pending & $past(rise_hit)) == $past(rise_hit));
   endsequence

   AST_RISE_LOGGED: assert property (@(posedge clk) disable iff (!rst_n)
      s_rise_seen |=> s_rise_logged)
      else $error("enabled rising edge did not set pending");

   AST_FALL_LOGGED: assert property (@(posedge clk) disable iff (!rst_n)
      (fall_hit != 16'h0000) |=> ((st.pending & $past(fall_hit)) == $past(fall_hit)))
      else $error("enabled falling edge did not set pending");

   AST_MASKED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
      ((next_st.pending & next_st.irq_en) == 16'h0000) |=> !irq)
      else $error("interrupt raised with every pending line masked");

   AST_EVT_GATED: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> (evt_out == ($past(hit) & $past(st.evt_en))))
      else $error("event output not gated by its enable");

   AST_PENDING_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> (($past(st.pending) & ~$past(w1c) & ~st.pending) == 16'h0000))
      else $error("pending bit dropped without a clear");

   AST_CATCH_PASSES: assert property (@(posedge clk) disable iff (!rst_n)
      (st.rise_s2 != st.rise_s3) && (st.rise_en == 16'hFFFF) |=> (st.pending != 16'h0000))
      else $error("caught edge did not reach pending");

   AST_WAKE_TIED: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 (wake == (irq | (evt_out != 16'h0000))))
      else $error("wake does not follow interrupt and event requests");

   AST_IRQ_RAISED: assert property (@(posedge clk) disable iff (!rst_n)
      ((hit & next_st.irq_en) != 16'h0000) |=> irq)
      else $error("unmasked edge did not raise interrupt");

   AST_CLEAR_WORKS: assert property (@(posedge clk) disable iff (!rst_n)
      (w1c != 16'h0000) && ((w1c & hit) == 16'h0000) |=> ((st.pending & $past(w1c)) == 16'h0000))
      else $error("write of one did not clear pending");
endmodule // eled_top

`default_nettype wire

// file: tb/eled_pin_model.sv
// pin side model: drives the external lines as held levels and short pulses
`timescale 1ns/100ps
`default_nettype none
module eled_pin_model (
   // pins toward the block
   output var logic [31:0] gpio_pins
);
   initial gpio_pins = 32'h0000_0000;
   // pins are driven inputs with no pull, so a line keeps its level between commands
   task automatic set_pin(input int idx, input logic lvl);
      gpio_pins[idx] = lvl;
   endtask
   // pulse shorter than one clk period, so only the asynchronous catcher can see it
   task automatic pulse(input int idx, input realtime width);
      gpio_pins[idx] = ~gpio_pins[idx];
      #(width) gpio_pins[idx] = ~gpio_pins[idx];
   endtask
endmodule // eled_pin_model
`default_nettype wire

// file: tb/eled_top_bench.sv
// self-checking bench for the external line event detector
`timescale 1ns/100ps
`default_nettype none
module eled_top_bench;
   import eled_pkg::*;
   logic          clk;
   logic          reset_n;
   eled_bus_req_t bus;
   logic [31:0]   rd_data;
   logic [31:0]   gpio_pins;
   logic          irq;
   logic [15:0]   evt_out;
   logic          wake;
   logic [15:0]   evt_seen;
   logic          wake_seen;
   logic          seen_clr;
   logic [31:0]   got;
   int            fail_count;
   int            checks_done;
   int            cyc;
   localparam logic [7:0] OFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h14};
   eled_top DUT (.clk(clk), .reset_n(reset_n), .bus(bus), .rd_data(rd_data),
                 .gpio_pins(gpio_pins), .irq(irq), .evt_out(evt_out), .wake(wake));
   eled_pin_model PM (.gpio_pins(gpio_pins));
   initial clk = 1'b0;
   always #5 clk = ~clk;
   // one-cycle pulses are collected so a test can look at them later; cleared only here to avoid a race
   always @(posedge clk) begin
      evt_seen  <= (!reset_n || seen_clr) ? 16'h0000 : (evt_seen | evt_out);
      wake_seen <= (!reset_n || seen_clr) ? 1'b0 : (wake_seen | wake);
      cyc       <= reset_n ? cyc + 1 : 0;
      if (cyc == 2000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
      #1 got = rd_data;
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: addr %h read %h expected %h", $time, a, got, exp);
      end
   endtask
   task automatic chk_bit(input logic v, input logic exp);
      checks_done++;
      if (v !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: output %b expected %b", $time, v, exp);
      end
   endtask
   // catcher, resync and pending take three edges; eight leaves margin
   task automatic settle();
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      bus = '0;
      fail_count = 0;
      checks_done = 0;
      seen_clr = 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      wr(8'h14, 32'hFFFF_FFFF);
      foreach (OFS[i]) chk_reg(OFS[i], 32'h0);
      wr(ELED_OFS_EVT_EN, 32'h0000_A5C3);
      chk_reg(ELED_OFS_EVT_EN, 32'h0000_A5C3);
      wr(ELED_OFS_SEL0, 32'h1100_0000);
      chk_reg(ELED_OFS_SEL0, 32'h1100_0000);
      $display("test registers done");
      for (int m = 1; m <= 3; m++) begin
         wr(ELED_OFS_RISE_EN, m[0] ? 32'h8 : 32'h0);
         wr(ELED_OFS_FALL_EN, m[1] ? 32'h8 : 32'h0);
         PM.set_pin(17, 1'b1);
         settle();
         chk_reg(ELED_OFS_PENDING, m[0] ? 32'h8 : 32'h0);
         wr(ELED_OFS_PENDING, 32'h8);
         PM.set_pin(17, 1'b0);
         settle();
         chk_reg(ELED_OFS_PENDING, m[1] ? 32'h8 : 32'h0);
         wr(ELED_OFS_PENDING, 32'h8);
      end
      $display("test edge modes done");
      wr(ELED_OFS_FALL_EN, 32'h0);
      wr(ELED_OFS_EVT_EN, 32'h8);
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      PM.pulse(17, 3.0);
      settle();
      chk_reg(ELED_OFS_PENDING, 32'h8);
      chk_bit(irq, 1'b0);
      chk_bit(evt_seen[3], 1'b1);
      chk_bit(wake_seen, 1'b1);
      wr(ELED_OFS_IRQ_EN, 32'h8);
      settle();
      chk_bit(irq, 1'b1);
      wr(ELED_OFS_PENDING, 32'h8);
      settle();
      chk_bit(irq, 1'b0);
      chk_reg(ELED_OFS_PENDING, 32'h0);
      $display("test pulse and mask done");
      wr(ELED_OFS_SEL3, 32'h1F00_0000);
      wr(ELED_OFS_RISE_EN, 32'h8008);
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      PM.pulse(31, 3.0);
      settle();
      chk_reg(ELED_OFS_PENDING, 32'h8000);
      // line 15 has neither event nor interrupt enabled, so nothing may leave the block
      chk_bit(evt_seen[15], 1'b0);
      chk_bit(irq, 1'b0);
      chk_bit(wake_seen, 1'b0);
      $display("test routing done");
      end_sim();
   end
endmodule // eled_top_bench
`default_nettype wire
